/* pkg/cgr_regs.svh */
// Register offsets, field positions, reset values and codes for the control-input counter block.
// Assumes an 8-bit word address on a plain strobe port with 32-bit data.
//
// Function
// - Gate-and-reset mode: control fall loads primary gate with count minus previous count.
// - Gate-and-reset mode: after that load the primary counter clears to zero and keeps counting.
// - Gate-and-reset mode: control fall loads secondary gate with count minus previous count.
// - Gate-and-reset mode: after that load the secondary counter clears to zero and keeps counting.
// - Offset-and-start mode: both counters start counting on a control rising edge.
// - Both offset modes: control fall loads each counter from its offset register.
// - Plain offset mode: counters keep counting right after the offset load.
// - Both offset registers reset to zero.
// - Software can write both offset registers at their own addresses.
// - Secondary gate counter updates only in independent dual-count mode.
// - Independent mode: channel B rising edges increment the secondary counter.
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH

`define CGR_ADDR_CTRL   8'h00
`define CGR_ADDR_CNT_P  8'h01
`define CGR_ADDR_CNT_S  8'h02
`define CGR_ADDR_GATE_P 8'h03
`define CGR_ADDR_GATE_S 8'h04
`define CGR_ADDR_OFF_P  8'h79
`define CGR_ADDR_OFF_S  8'h7A

`define CGR_MODE_LSB    0
`define CGR_MODE_MSB    1
`define CGR_INDEP_BIT   2

`define CGR_CTRL_RESET  3'h0
`define CGR_OFF_RESET   32'h0000_0000

`endif

/* pkg/cgr_pkg.sv */
// Types shared by the control-input counter block.
// Assumes the register header is compiled alongside it.
package cgr_pkg;

    typedef enum logic [1:0]
    {
        CGR_MODE_FREE = 2'h0,
        CGR_MODE_GCR  = 2'h1,
        CGR_MODE_ROS  = 2'h2,
        CGR_MODE_RO   = 2'h3
    } cgr_mode_t;

    typedef enum logic [1:0]
    {
        CGR_ST_RUN  = 2'b01,
        CGR_ST_HOLD = 2'b10
    } cgr_state_t;

    typedef struct packed
    {
        logic      indep;
        cgr_mode_t mode;
    } cgr_ctrl_t;

endpackage

/* core/cgr_top.sv */
// Control-input counter block: primary and secondary counters, gate counters and offsets.
// Assumes channel inputs synchronous to clock and a single-cycle strobe register port.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "cgr_regs.svh"

module cgr_top
    import cgr_pkg::*;
#(
    parameter int W = 32
)
(
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          sig_a,
    input  wire logic          sig_b,
    input  wire logic          sig_c,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr_stb,
    input  wire logic          rd_stb,
    output logic      [31:0]   rdata,
    output logic      [W-1:0]  cnt_p,
    output logic      [W-1:0]  cnt_s,
    output logic      [W-1:0]  gate_p,
    output logic      [W-1:0]  gate_s
);

    ////////////////////////////////////////////////////////////////////////////
    logic       c_s1_q;
    logic       c_s2_q;
    logic       c_s3_q;
    logic       a_q;
    logic       b_q;
    logic       rise_a;
    logic       rise_b;
    logic       rise_c;
    logic       fall_c;

    // The control line comes from switches and sensors, so it is resynchronised
    // even though the channel lines are trusted to be synchronous.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            c_s1_q <= 1'b1;
            c_s2_q <= 1'b1;
            c_s3_q <= 1'b1;
        end
        else
        begin
            c_s1_q <= sig_c;
            c_s2_q <= c_s1_q;
            c_s3_q <= c_s2_q;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end
        else
        begin
            a_q <= sig_a;
            b_q <= sig_b;
        end
    end

    assign rise_a = sig_a & ~a_q;
    assign rise_b = sig_b & ~b_q;
    assign rise_c = c_s2_q & ~c_s3_q;
    assign fall_c = ~c_s2_q & c_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    cgr_ctrl_t  ctrl_q;
    logic [W-1:0] off_p_q;
    logic [W-1:0] off_s_q;
    logic       wr_ctrl;
    logic       wr_off_p;
    logic       wr_off_s;

    assign wr_ctrl  = wr_stb && (addr == `CGR_ADDR_CTRL);
    assign wr_off_p = wr_stb && (addr == `CGR_ADDR_OFF_P);
    assign wr_off_s = wr_stb && (addr == `CGR_ADDR_OFF_S);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ctrl_q <= cgr_ctrl_t'(`CGR_CTRL_RESET);
        else if (wr_ctrl)
            ctrl_q <= cgr_ctrl_t'(wdata[`CGR_INDEP_BIT:`CGR_MODE_LSB]);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            off_p_q <= W'(`CGR_OFF_RESET);
            off_s_q <= W'(`CGR_OFF_RESET);
        end
        else
        begin
            if (wr_off_p)
                off_p_q <= wdata[W-1:0];
            if (wr_off_s)
                off_s_q <= wdata[W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    cgr_state_t state_q;
    logic       is_gcr;
    logic       is_off;
    logic       run;

    assign is_gcr = (ctrl_q.mode == CGR_MODE_GCR);
    assign is_off = (ctrl_q.mode == CGR_MODE_ROS) || (ctrl_q.mode == CGR_MODE_RO);
    // A hold left by a mode change must not swallow the edge of that same cycle.
    assign run    = ((state_q == CGR_ST_RUN) || (ctrl_q.mode != CGR_MODE_ROS)) && !fall_c;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_q <= CGR_ST_RUN;
        else
        begin
            case (state_q)
                CGR_ST_RUN:
                    if (fall_c && ctrl_q.mode == CGR_MODE_ROS)
                        state_q <= CGR_ST_HOLD;
                CGR_ST_HOLD:
                    if (rise_c || ctrl_q.mode != CGR_MODE_ROS)
                        state_q <= CGR_ST_RUN;
                default:
                    state_q <= CGR_ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [W-1:0] cnt_p_q;
    logic [W-1:0] cnt_s_q;
    logic [W-1:0] prev_p_q;
    logic [W-1:0] prev_s_q;
    logic [W-1:0] gate_p_q;
    logic [W-1:0] gate_s_q;
    logic [1:0]   inc_p;
    logic         inc_s;

    // Without the independent mode channel B adds into the primary counter.
    assign inc_p = {1'b0, rise_a} + {1'b0, rise_b & ~ctrl_q.indep};
    assign inc_s = rise_b & ctrl_q.indep;

    // A channel edge in the very cycle of a control fall is dropped in every mode; outside
    // free mode the counter is being cleared or reloaded and that edge belongs to neither side.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cnt_p_q <= '0;
        else if (fall_c && is_gcr)
            cnt_p_q <= '0;
        else if (fall_c && is_off)
            cnt_p_q <= off_p_q;
        else if (run)
            cnt_p_q <= cnt_p_q + W'(inc_p);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cnt_s_q <= '0;
        else if (fall_c && is_gcr)
            cnt_s_q <= '0;
        else if (fall_c && is_off)
            cnt_s_q <= off_s_q;
        else if (run && inc_s)
            cnt_s_q <= cnt_s_q + W'(1);
    end

    // The previous-edge snapshot follows every control fall, so a switch into
    // gate-and-reset mode measures from the last real edge.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_p_q <= '0;
            prev_s_q <= '0;
        end
        else if (fall_c)
        begin
            prev_p_q <= is_gcr ? '0 : (is_off ? off_p_q : cnt_p_q);
            prev_s_q <= is_gcr ? '0 : (is_off ? off_s_q : cnt_s_q);
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            gate_p_q <= '0;
            gate_s_q <= '0;
        end
        else if (fall_c && is_gcr)
        begin
            gate_p_q <= cnt_p_q - prev_p_q;
            if (ctrl_q.indep)
                gate_s_q <= cnt_s_q - prev_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;

    function automatic logic [31:0] widen(input logic [W-1:0] v);
        widen = 32'(v);
    endfunction

    always_comb
    begin
        case (addr)
            `CGR_ADDR_CTRL:   rd_mux = {29'h0, ctrl_q};
            `CGR_ADDR_CNT_P:  rd_mux = widen(cnt_p_q);
            `CGR_ADDR_CNT_S:  rd_mux = widen(cnt_s_q);
            `CGR_ADDR_GATE_P: rd_mux = widen(gate_p_q);
            `CGR_ADDR_GATE_S: rd_mux = widen(gate_s_q);
            `CGR_ADDR_OFF_P:  rd_mux = widen(off_p_q);
            `CGR_ADDR_OFF_S:  rd_mux = widen(off_s_q);
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stand for exactly one cycle after the strobe, zero otherwise.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= 32'h0000_0000;
        else if (rd_stb)
            rdata_q <= rd_mux;
        else
            rdata_q <= 32'h0000_0000;
    end

    assign rdata  = rdata_q;
    assign cnt_p  = cnt_p_q;
    assign cnt_s  = cnt_s_q;
    assign gate_p = gate_p_q;
    assign gate_s = gate_s_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_gate_p;
        (fall_c && is_gcr) |=> (gate_p_q == $past(cnt_p_q) - $past(prev_p_q));
    endproperty
    a_gate_p: assert property (p_gate_p) else $error("primary gate load wrong");

    property p_clr_p;
        (fall_c && is_gcr) |=> (cnt_p_q == '0);
    endproperty
    a_clr_p: assert property (p_clr_p) else $error("primary not cleared");

    property p_gate_s;
        (fall_c && is_gcr && ctrl_q.indep)
            |=> (gate_s_q == $past(cnt_s_q) - $past(prev_s_q));
    endproperty
    a_gate_s: assert property (p_gate_s) else $error("secondary gate load wrong");

    property p_clr_s;
        (fall_c && is_gcr) |=> (cnt_s_q == '0);
    endproperty
    a_clr_s: assert property (p_clr_s) else $error("secondary not cleared");

    property p_start;
        (state_q == CGR_ST_HOLD && rise_c) |=> (state_q == CGR_ST_RUN);
    endproperty
    a_start: assert property (p_start) else $error("no start on control rise");

    property p_offload;
        (fall_c && is_off)
            |=> (cnt_p_q == $past(off_p_q)) && (cnt_s_q == $past(off_s_q));
    endproperty
    a_offload: assert property (p_offload) else $error("offset load wrong");

    property p_keep;
        (ctrl_q.mode == CGR_MODE_RO && rise_a && !rise_b && !fall_c)
            |=> (cnt_p_q == $past(cnt_p_q) + W'(1));
    endproperty
    a_keep: assert property (p_keep) else $error("counting paused");

    property p_wr_off;
        wr_off_p |=> (off_p_q == $past(wdata[W-1:0]));
    endproperty
    a_wr_off: assert property (p_wr_off) else $error("offset write lost");

    property p_gate_s_dual;
        !ctrl_q.indep |=> $stable(gate_s_q);
    endproperty
    a_gate_s_dual: assert property (p_gate_s_dual) else $error("secondary gate moved");

    property p_inc_s;
        (ctrl_q.indep && rise_b && run) |=> (cnt_s_q == $past(cnt_s_q) + W'(1));
    endproperty
    a_inc_s: assert property (p_inc_s) else $error("secondary missed edge");

    property p_one_edge;
        fall_c |=> !fall_c;
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("control edge doubled");

    property p_hold;
        (state_q == CGR_ST_HOLD && !rise_c && !fall_c && ctrl_q.mode == CGR_MODE_ROS)
            |=> $stable(cnt_p_q) && $stable(cnt_s_q);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while held");

    c_gcr:  cover property (fall_c && is_gcr ##[1:50] fall_c && is_gcr);
    c_ros:  cover property (fall_c && ctrl_q.mode == CGR_MODE_ROS ##[1:50] rise_c);
    c_ro:   cover property (fall_c && ctrl_q.mode == CGR_MODE_RO ##1 rise_a);
    c_dual: cover property (ctrl_q.indep && rise_b && run);

endmodule // cgr_top

/* bench/cgr_field_model.sv */
// Field-side model: two pulse sensors on channels A and B and a switch on the control input.
// Assumes the bench asks for pulses one cycle at a time and never on A and B together.
`timescale 1ns/1ns

module cgr_field_model
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic a_go,
    input  wire logic b_go,
    input  wire logic c_lvl,
    input  wire logic slow,
    output logic      sig_a,
    output logic      sig_b,
    output logic      sig_c
);
    logic [1:0] a_left_q;
    logic [1:0] b_left_q;

    ////////////////////////////////////////////////////////////////////////////////
    // The switch rests high, so a released contact never reads as a fall.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sig_c <= 1'b1;
        else
            sig_c <= c_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A slow sensor holds its pulse for three cycles instead of one.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            a_left_q <= 2'h0;
        else if (a_go)
            a_left_q <= slow ? 2'h3 : 2'h1;
        else if (a_left_q != 2'h0)
            a_left_q <= a_left_q - 2'h1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            b_left_q <= 2'h0;
        else if (b_go)
            b_left_q <= slow ? 2'h3 : 2'h1;
        else if (b_left_q != 2'h0)
            b_left_q <= b_left_q - 2'h1;
    end

    assign sig_a = (a_left_q != 2'h0);
    assign sig_b = (b_left_q != 2'h0);

endmodule // cgr_field_model

/* bench/counter_gate_reset_offset_control_bench.sv */
// Self-checking bench for the control-input counter block.
// Assumes the field model drives the channels and every result is read over the register port.
`timescale 1ns/1ns
`include "cgr_regs.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end

module counter_gate_reset_offset_control_bench;
    logic        clock, rstn, a_go, b_go, c_lvl, slow, wr_stb, rd_stb, rd_q;
    logic        sig_a, sig_b, sig_c;
    logic [7:0]  addr, ra_q;
    logic [31:0] wdata, rdata, cnt_p, cnt_s, gate_p, gate_s, off_p, off_s, exp_v;
    logic [31:0] exp_q[$];
    logic [15:0] rnd;
    int          num_errors, n_tests, na, nb;

    cgr_top #(.W(32)) u_cgr_top (.clock(clock), .rstn(rstn), .sig_a(sig_a), .sig_b(sig_b),
        .sig_c(sig_c), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .cnt_p(cnt_p), .cnt_s(cnt_s), .gate_p(gate_p), .gate_s(gate_s));

    cgr_field_model u_cgr_field_model (.clock(clock), .rstn(rstn), .a_go(a_go), .b_go(b_go),
        .c_lvl(c_lvl), .slow(slow), .sig_a(sig_a), .sig_b(sig_b), .sig_c(sig_c));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic next_rnd();
        rnd = lfsr(rnd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    // The expectation is queued first; the monitor pairs it with the read data.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask

    task automatic set_c(input logic v);
        @(posedge clock);
        c_lvl <= v;
        repeat (6) @(posedge clock);
    endtask

    task automatic pulses(input int n_a, input int n_b);
        for (int i = 0; i < n_a + n_b; i++)
        begin
            next_rnd();
            @(posedge clock);
            a_go <= (i < n_a);
            b_go <= (i >= n_a);
            slow <= rnd[0];
            @(posedge clock);
            a_go <= 1'b0;
            b_go <= 1'b0;
            repeat (5) @(posedge clock);
        end
    endtask

    task automatic test_done();
        repeat (3) @(posedge clock);
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge clock)
    begin
        if (rd_q)
        begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
            if (ra_q == `CGR_ADDR_CNT_P)
                `CHK(cnt_p, exp_v)
            if (ra_q == `CGR_ADDR_CNT_S)
                `CHK(cnt_s, exp_v)
            if (ra_q == `CGR_ADDR_GATE_P)
                `CHK(gate_p, exp_v)
            if (ra_q == `CGR_ADDR_GATE_S)
                `CHK(gate_s, exp_v)
        end
        rd_q <= rd_stb;
        ra_q <= addr;
    end

    initial
    begin
        #80000;
        num_errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0; a_go = 1'b0; b_go = 1'b0; c_lvl = 1'b1; slow = 1'b0;
        wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
        rnd = 16'h908B;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(`CGR_ADDR_OFF_P, 32'h0000_0000);
        rd(`CGR_ADDR_OFF_S, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000);
        $display("Test reset values done");
        next_rnd(); off_p[31:16] = rnd; next_rnd(); off_p[15:0] = rnd;
        next_rnd(); off_s[31:16] = rnd; next_rnd(); off_s[15:0] = rnd;
        wr(`CGR_ADDR_OFF_P, off_p);
        wr(`CGR_ADDR_OFF_S, off_s);
        rd(`CGR_ADDR_OFF_P, off_p);
        rd(`CGR_ADDR_OFF_S, off_s);
        $display("Test offset write done");
        wr(`CGR_ADDR_CTRL, 32'h0000_0005);
        set_c(1'b0);
        set_c(1'b1);
        next_rnd(); na = rnd[2:0] + 1; nb = rnd[5:3] + 1;
        pulses(na, nb);
        rd(`CGR_ADDR_CNT_S, 32'(nb));
        set_c(1'b0);
        rd(`CGR_ADDR_GATE_P, 32'(na));
        rd(`CGR_ADDR_GATE_S, 32'(nb));
        rd(`CGR_ADDR_CNT_P, 32'h0000_0000);
        rd(`CGR_ADDR_CNT_S, 32'h0000_0000);
        set_c(1'b1);
        pulses(na + 2, 1);
        set_c(1'b0);
        rd(`CGR_ADDR_GATE_P, 32'(na + 2));
        rd(`CGR_ADDR_GATE_S, 32'h0000_0001);
        wr(`CGR_ADDR_CTRL, 32'h0000_0001);
        set_c(1'b1);
        pulses(na, nb);
        set_c(1'b0);
        rd(`CGR_ADDR_GATE_P, 32'(na + nb));
        rd(`CGR_ADDR_GATE_S, 32'h0000_0001);
        $display("Test gate count and clear done");
        wr(`CGR_ADDR_CTRL, 32'h0000_0007);
        set_c(1'b1);
        pulses(1, 1);
        set_c(1'b0);
        rd(`CGR_ADDR_CNT_P, off_p);
        rd(`CGR_ADDR_CNT_S, off_s);
        pulses(na, nb);
        rd(`CGR_ADDR_CNT_P, off_p + 32'(na));
        rd(`CGR_ADDR_CNT_S, off_s + 32'(nb));
        $display("Test offset reload done");
        wr(`CGR_ADDR_CTRL, 32'h0000_0006);
        set_c(1'b1);
        pulses(2, 2);
        set_c(1'b0);
        pulses(na, nb);
        rd(`CGR_ADDR_CNT_P, off_p);
        rd(`CGR_ADDR_CNT_S, off_s);
        set_c(1'b1);
        pulses(na, nb);
        rd(`CGR_ADDR_CNT_P, off_p + 32'(na));
        rd(`CGR_ADDR_CNT_S, off_s + 32'(nb));
        $display("Test offset hold and start done");
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(`CGR_ADDR_OFF_P, 32'h0000_0000);
        rd(`CGR_ADDR_OFF_S, 32'h0000_0000);
        rd(`CGR_ADDR_CNT_P, 32'h0000_0000);
        $display("Test reset in run done");
        test_done();
    end

endmodule // counter_gate_reset_offset_control_bench
